//--- rtl/hpm_headphone_mixer_regs.sv
// How it works
// R1: Mixer bit 7 connects its source to the driver; reset leaves it disconnected.
// R2: Mixer bits 6..0 hold a read/write attenuation code, reset to zero.
// R3: Level bits 7..4 set driver gain 0 to 9 dB, reset 0.
// R4: Software never writes gain codes 10 to 15; they are reserved.
// R5: Level bit 3 unmutes the driver when set; reset leaves it muted.
// R6: Level bit 2 picks high impedance (1, reset) or weak common mode when down.
// R7: Level bit 1 reads 1 while any left-common gain (level or 0x37..0x39 mixer) is still ramping; right driver gains are not tracked.
// R8: Level bit 0 fully powers the driver up when set; reset is 0.
// R9: Offsets 0x37..0x39 feed left-common, 0x3a its level, 0x3b..0x3f right driver.
// R10: Right driver takes the left DAC channel with its own enable and code.
// R11: Writable fields read back as written; status shows ramp progress only.
module hpm_headphone_mixer_regs
    import hpm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port behind the control bus
    input hpm_reg_req_t reg_req,
    output logic [DATA_W-1:0] reg_rdata,
    // Left-common driver
    output hpm_mix_t left_com_mix [NUM_LCOM_SRC],
    output hpm_drv_t left_com_drv,
    output logic vol_pending,
    // Right driver
    output hpm_mix_t right_hp_mix [NUM_RHP_SRC]
);

    hpm_mix_t lcom_setting [NUM_LCOM_SRC];
    hpm_mix_t rhp_setting [NUM_RHP_SRC];
    logic [NUM_LCOM_SRC-1:0] lcom_settled;
    logic [NUM_LCOM_SRC-1:0] lcom_wr;
    logic [NUM_RHP_SRC-1:0] rhp_wr;
    hpm_drv_t drv_setting;
    logic [LEVEL_W-1:0] level_applied;
    logic [RAMP_CNT_W-1:0] ramp_cnt;
    logic step;
    logic level_wr;
    logic gain_wr;
    logic level_settled;
    logic all_settled;
    logic next_pending;
    logic in_lcom;
    logic in_rhp;
    logic [ADDR_W-1:0] lcom_idx;
    logic [ADDR_W-1:0] rhp_idx;
    logic [DATA_W-1:0] level_readback;
    logic [DATA_W-1:0] rd_value;

    // Address decode
    assign in_lcom = reg_req.addr >= OFS_RIGHT_LINE_TO_LEFT_COM_MIX
        && reg_req.addr <= OFS_RIGHT_DAC_TO_LEFT_COM_MIX; // R9
    assign in_rhp = reg_req.addr >= OFS_LEFT_LINE_TO_RIGHT_HP_MIX
        && reg_req.addr <= OFS_RIGHT_PREAMP_TO_RIGHT_HP_MIX; // R9
    assign lcom_idx = reg_req.addr - OFS_RIGHT_LINE_TO_LEFT_COM_MIX;
    assign rhp_idx = reg_req.addr - OFS_LEFT_LINE_TO_RIGHT_HP_MIX;
    assign level_wr = reg_req.write && reg_req.addr == OFS_LEFT_COM_DRIVER_LEVEL; // R9

    // Any write touching a left-common gain restarts the pending flag
    assign gain_wr = level_wr || (|lcom_wr);

    // Ramp tick shared by every gain path
    assign step = ramp_cnt == RAMP_CNT_LAST;

    always_ff @(posedge clock) begin
        if (reset || step) begin
            ramp_cnt <= RAMP_CNT_ZERO;
        end else begin
            ramp_cnt <= ramp_cnt + 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_LCOM_SRC; i++) begin : g_lcom
            assign lcom_wr[i] = reg_req.write && in_lcom && lcom_idx == ADDR_W'(i);
            hpm_mix_cell u_cell (
                .clock(clock),
                .reset(reset),
                .wr_en(lcom_wr[i]),
                .wdata(reg_req.wdata),
                .step(step),
                .setting(lcom_setting[i]),
                .applied(left_com_mix[i]),
                .settled(lcom_settled[i])
            );
        end
        // Index 2 is the left DAC channel path
        for (i = 0; i < NUM_RHP_SRC; i++) begin : g_rhp
            assign rhp_wr[i] = reg_req.write && in_rhp && rhp_idx == ADDR_W'(i); // R10
            hpm_mix_cell u_cell (
                .clock(clock),
                .reset(reset),
                .wr_en(rhp_wr[i]),
                .wdata(reg_req.wdata),
                .step(step),
                .setting(rhp_setting[i]),
                .applied(right_hp_mix[i]),
                .settled()
            );
        end
    endgenerate

    // Level register; reserved gain codes are stored as given, software keeps them out
    always_ff @(posedge clock) begin
        if (reset) begin
            drv_setting.level <= LEVEL_RESET; // R3
            drv_setting.unmute <= UNMUTE_RESET; // R5
            drv_setting.hiz_when_down <= HIZ_RESET; // R6
            drv_setting.power_up <= POWER_RESET; // R8
        end else if (level_wr) begin
            drv_setting.level <= reg_req.wdata[LEVEL_MSB:LEVEL_LSB]; // R3
            drv_setting.unmute <= reg_req.wdata[UNMUTE_BIT]; // R5
            drv_setting.hiz_when_down <= reg_req.wdata[HIZ_BIT]; // R6
            drv_setting.power_up <= reg_req.wdata[POWER_BIT]; // R8
        end
    end

    // Output gain ramps one dB per step
    always_ff @(posedge clock) begin
        if (reset) begin
            level_applied <= LEVEL_RESET;
        end else if (step && level_applied < drv_setting.level) begin
            level_applied <= level_applied + 4'h1; // R3
        end else if (step && level_applied > drv_setting.level) begin
            level_applied <= level_applied - 4'h1; // R3
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            left_com_drv.level <= LEVEL_RESET;
            left_com_drv.unmute <= UNMUTE_RESET;
            left_com_drv.hiz_when_down <= HIZ_RESET;
            left_com_drv.power_up <= POWER_RESET;
        end else begin
            left_com_drv.level <= level_applied; // R3
            left_com_drv.unmute <= drv_setting.unmute; // R5
            left_com_drv.hiz_when_down <= drv_setting.hiz_when_down; // R6
            left_com_drv.power_up <= drv_setting.power_up; // R8
        end
    end

    // Status only clears on a ramp tick, so it never reads settled mid-write
    assign level_settled = level_applied == drv_setting.level;
    assign all_settled = level_settled && (&lcom_settled);
    assign next_pending = gain_wr ? 1'b1 : (step ? !all_settled : vol_pending); // R7

    always_ff @(posedge clock) begin
        if (reset) begin
            vol_pending <= STATUS_RESET; // R7
        end else begin
            vol_pending <= next_pending; // R7
        end
    end

    // Readback
    assign level_readback = {drv_setting.level, drv_setting.unmute,
        drv_setting.hiz_when_down, vol_pending, drv_setting.power_up}; // R11
    assign rd_value = in_lcom ? lcom_setting[lcom_idx[1:0]]
        : in_rhp ? rhp_setting[rhp_idx[2:0]]
        : reg_req.addr == OFS_LEFT_COM_DRIVER_LEVEL ? level_readback
        : UNMAPPED_RDATA; // R11

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= RDATA_RESET;
        end else if (reg_req.read) begin
            reg_rdata <= rd_value; // R11
        end
    end

endmodule

//--- rtl/hpm_mix_cell.sv
module hpm_mix_cell
    import hpm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register write and ramp tick
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic step,
    // State
    output hpm_mix_t setting,
    output hpm_mix_t applied,
    output logic settled
);

    logic atten_up;
    logic atten_down;

    assign atten_up = applied.atten < setting.atten;
    assign atten_down = applied.atten > setting.atten;
    assign settled = applied == setting;

    always_ff @(posedge clock) begin
        if (reset) begin
            setting.route <= ROUTE_RESET; // R1
            setting.atten <= ATTEN_RESET; // R2
        end else if (wr_en) begin
            setting.route <= wdata[ROUTE_BIT]; // R1
            setting.atten <= wdata[ATTEN_MSB:0]; // R2
        end
    end

    // Attenuation walks one code per step to avoid zipper noise
    always_ff @(posedge clock) begin
        if (reset) begin
            applied.route <= ROUTE_RESET;
            applied.atten <= ATTEN_RESET;
        end else begin
            applied.route <= setting.route; // R1
            if (step && atten_up) begin
                applied.atten <= applied.atten + 7'h01;
            end else if (step && atten_down) begin
                applied.atten <= applied.atten - 7'h01;
            end
        end
    end

endmodule

//--- rtl/hpm_pkg.sv
package hpm_pkg;

    // Register port widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int ATTEN_W = 7;
    localparam int LEVEL_W = 4;

    // Register offsets on page 0
    localparam logic [ADDR_W-1:0] OFS_RIGHT_LINE_TO_LEFT_COM_MIX = 7'h37;
    localparam logic [ADDR_W-1:0] OFS_RIGHT_PREAMP_TO_LEFT_COM_MIX = 7'h38;
    localparam logic [ADDR_W-1:0] OFS_RIGHT_DAC_TO_LEFT_COM_MIX = 7'h39;
    localparam logic [ADDR_W-1:0] OFS_LEFT_COM_DRIVER_LEVEL = 7'h3a;
    localparam logic [ADDR_W-1:0] OFS_LEFT_LINE_TO_RIGHT_HP_MIX = 7'h3b;
    localparam logic [ADDR_W-1:0] OFS_LEFT_PREAMP_TO_RIGHT_HP_MIX = 7'h3c;
    localparam logic [ADDR_W-1:0] OFS_LEFT_DAC_TO_RIGHT_HP_MIX = 7'h3d;
    localparam logic [ADDR_W-1:0] OFS_RIGHT_LINE_TO_RIGHT_HP_MIX = 7'h3e;
    localparam logic [ADDR_W-1:0] OFS_RIGHT_PREAMP_TO_RIGHT_HP_MIX = 7'h3f;

    // Source counts per driver
    localparam int NUM_LCOM_SRC = 3;
    localparam int NUM_RHP_SRC = 5;

    // Field positions
    localparam int ROUTE_BIT = 7;
    localparam int ATTEN_MSB = 6;
    localparam int LEVEL_MSB = 7;
    localparam int LEVEL_LSB = 4;
    localparam int UNMUTE_BIT = 3;
    localparam int HIZ_BIT = 2;
    localparam int STATUS_BIT = 1;
    localparam int POWER_BIT = 0;

    // Reset values
    localparam logic ROUTE_RESET = 1'b0;
    localparam logic [ATTEN_W-1:0] ATTEN_RESET = 7'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
    localparam logic UNMUTE_RESET = 1'b0;
    localparam logic HIZ_RESET = 1'b1;
    localparam logic STATUS_RESET = 1'b1;
    localparam logic POWER_RESET = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;

    // Gain ramp timing: one code step per interval
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int RAMP_STEP_NS = 20000;
    localparam int RAMP_STEP_CYCLES = RAMP_STEP_NS / CLOCK_PERIOD_NS;
    localparam int RAMP_CNT_W = $clog2(RAMP_STEP_CYCLES);
    localparam logic [RAMP_CNT_W-1:0] RAMP_CNT_LAST = RAMP_CNT_W'(RAMP_STEP_CYCLES - 1);
    localparam logic [RAMP_CNT_W-1:0] RAMP_CNT_ZERO = '0;

    typedef struct packed {
        logic route;
        logic [ATTEN_W-1:0] atten;
    } hpm_mix_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic unmute;
        logic hiz_when_down;
        logic power_up;
    } hpm_drv_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hpm_reg_req_t;

endpackage

//--- testbench/hpm_regs_props.sv
module hpm_regs_props
    import hpm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input hpm_reg_req_t reg_req,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Driver state
    input hpm_mix_t left_com_mix [NUM_LCOM_SRC],
    input hpm_drv_t left_com_drv,
    input wire logic vol_pending,
    input hpm_mix_t right_hp_mix [NUM_RHP_SRC]
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire lvl_wr = reg_req.write && reg_req.addr == OFS_LEFT_COM_DRIVER_LEVEL;
    wire lcom_wr = reg_req.write && reg_req.addr inside
        {[OFS_RIGHT_LINE_TO_LEFT_COM_MIX:OFS_LEFT_COM_DRIVER_LEVEL]};
    wire rd_only = reg_req.read && !reg_req.write;

    unmapped_read_a: assert property (
        rd_only && reg_req.addr < 7'h37 |=> reg_rdata == 8'h00) else $error("unmapped read");
    reset_drv_a: assert property (
        $past(reset) |-> left_com_drv == 7'h02 && vol_pending) else $error("reset state");
    // Driver fields pass through the setting flop and then the output flop
    drv_update_a: assert property (lvl_wr |-> ##2
        left_com_drv.unmute == $past(reg_req.wdata[3], 2)
        && left_com_drv.hiz_when_down == $past(reg_req.wdata[2], 2)
        && left_com_drv.power_up == $past(reg_req.wdata[0], 2)) else $error("drv update");
    pending_set_a: assert property (lvl_wr |=> vol_pending) else $error("no pending");
    pending_hold_a: assert property (
        !vol_pending && !lcom_wr |=> !vol_pending) else $error("pending rose");
    route_left_a: assert property (reg_req.write && reg_req.addr == 7'h37
        |-> ##2 left_com_mix[0].route == $past(reg_req.wdata[7], 2)) else $error("route");
    route_right_a: assert property (reg_req.write && reg_req.addr == 7'h3d
        |-> ##2 right_hp_mix[2].route == $past(reg_req.wdata[7], 2)) else $error("route");
    // Gain moves one code at a time so the path never jumps audibly
    atten_step_a: assert property (!$past(reset) && $changed(left_com_mix[1].atten)
        |-> ATTEN_W'(left_com_mix[1].atten - $past(left_com_mix[1].atten)) inside {7'h01, 7'h7f})
        else $error("atten jump");
    level_read_a: assert property (rd_only && reg_req.addr == 7'h3a
        |=> reg_rdata[3:2] == {$past(left_com_drv.unmute), $past(left_com_drv.hiz_when_down)})
        else $error("level readback");
    level_wr_c: cover property (lvl_wr);
    settle_c: cover property ($fell(vol_pending));
    unmapped_c: cover property (rd_only && reg_req.addr < 7'h37);
endmodule

//--- testbench/tb_headphone_mixer_route_regs.sv
module tb_headphone_mixer_route_regs import hpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic reset = 1'b1;
    hpm_reg_req_t reg_req = '0;
    logic [DATA_W-1:0] reg_rdata;
    hpm_mix_t left_com_mix [NUM_LCOM_SRC];
    hpm_drv_t left_com_drv;
    logic vol_pending;
    hpm_mix_t right_hp_mix [NUM_RHP_SRC];
    logic [7:0] mdl [9];
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 68;
    int v;
    int n;

    initial begin
        forever #10 clock = ~clock;
    end

    hpm_headphone_mixer_regs u_hpm_headphone_mixer_regs (.clock(clock), .reset(reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .left_com_mix(left_com_mix),
        .left_com_drv(left_com_drv), .vol_pending(vol_pending), .right_hp_mix(right_hp_mix));

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic op(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_req <= {w, r, a, d};
    endtask

    // Status bit is not stored, so the expected readback takes it separately
    function automatic logic [7:0] exp_rd(input int i, input logic p);
        return (i == 3) ? {mdl[3][7:2], p, mdl[3][0]} : mdl[i];
    endfunction

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            mdl[i] = (i == 3) ? 8'h04 : 8'h00;
        end
        #1;
        chk({1'b0, left_com_drv}, 8'h02);
        for (int i = 0; i < 3; i++) chk(left_com_mix[i], 8'h00);
        for (int j = 0; j < 5; j++) chk(right_hp_mix[j], 8'h00);
        for (int i = 0; i < 9; i++) begin
            rd(7'(55 + i), exp_rd(i, 1'b1));
        end
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        do_reset();
        // Slot 0 ramps furthest, so the status bit outlasts every other path
        for (int i = 0; i < 9; i++) begin
            v = $random(seed);
            mdl[i] = v[7:0] & ((i < 3) ? 8'h9f : 8'h8f);
            if (i == 0) mdl[i][4:0] = 5'h1f;
            if (i == 3) mdl[i] = {4'($unsigned(v) % 10), v[3:0]};
            op(1'b1, 1'b0, 7'(55 + i), mdl[i]);
        end
        op(1'b1, 1'b0, 7'h40, 8'hff);
        op(1'b0, 1'b0, 7'h00, 8'h00);
        @(posedge clock);
        #1;
        for (int i = 0; i < 3; i++) chk(8'(left_com_mix[i].route), 8'(mdl[i][7]));
        for (int j = 0; j < 5; j++) chk(8'(right_hp_mix[j].route), 8'(mdl[j + 4][7]));
        chk(8'({left_com_drv.unmute, left_com_drv.hiz_when_down, left_com_drv.power_up}),
            8'({mdl[3][3:2], mdl[3][0]}));
        for (int i = 0; i < 9; i++) rd(7'(55 + i), exp_rd(i, 1'b1));
        rd(7'h40, 8'h00);
        rd(7'h00, 8'h00);
        for (n = 0; n < 40000 && vol_pending !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        chk(8'(vol_pending), 8'h00);
        for (int i = 0; i < 3; i++) chk(left_com_mix[i], mdl[i]);
        for (int j = 0; j < 5; j++) chk(right_hp_mix[j], mdl[j + 4]);
        chk(8'(left_com_drv.level), 8'(mdl[3][7:4]));
        rd(7'h3a, exp_rd(3, 1'b0));
        do_reset();
        final_report();
    end
endmodule

bind hpm_headphone_mixer_regs hpm_regs_props u_props (.clock(clock), .reset(reset),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .left_com_mix(left_com_mix),
    .left_com_drv(left_com_drv), .vol_pending(vol_pending), .right_hp_mix(right_hp_mix));
